/* File: design/vls_line_sim.sv */
// Purpose: Line-side mode control, drivers and serial paths of a V.35 pod
// Assumes: analyzer_clock_source is the bit clock source at twice the line rate
// Notes:   Line clock outputs toggle on every rising analyzer_clock_source edge
//
// Function
// RL1: A mark on transmit data drives A negative relative to B.
// RL2: Transmit data changes in phase with clock; sampled at its falling crossing.
// RL3: Terminal side derives its external transmit clock from modem transmit clock; the pod derives it from analyzer_clock_source instead.
// RL4: Receive data changes at positive-going receive clock crossing, within ten percent.
// RL5: Modem side supplies a balanced transmit clock for data and external clock.
// RL6: Modem side sends no data unless request-to-send is ON.
// RL7: Terminal-ready ON lets a call be answered; OFF ends it.
// RL8: Terminal side sends data only while clear-to-send is ON.
// RL9: Data-set-ready ON means ready to accept data, if clear-to-send too.
// RL10: Receive data is reliable only while line-signal-detect is ON.
// RL11: Inhibit low turns both driver outputs off; L turns B, H turns A.
// RL12: In simulation modes the analyzer data and clock feed the drivers.
// RL13: Driver loads are switched out in monitor operation by the load switch.
// RL14: Each side's lines are driven by the pod only in its simulation mode.
// RL15: Five differential drivers: two data, three clock.
// RL16: A select pulse sets the matching mode flip-flop high.
// RL17: Load switch enable is high whenever either mode flip-flop is high.
// RL18: Analyzer pulses monitor select first, then the chosen simulation line.
// RL19: A monitor select pulse clears both mode flip-flops.
`timescale 1ns/1ps
module vls_line_sim #(
   parameter int WORD_BITS = vls_pkg::VLS_WORD_BITS
) (
   // APB slave
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Analyzer mode select pins
   input  wire logic                 monitor_pulse,
   input  wire logic                 terminal_sim_pulse,
   input  wire logic                 modem_sim_pulse,
   // Link clock and receivers
   input  wire logic                 analyzer_clock_source,
   input  wire logic                 sd_rx,
   input  wire logic                 rd_rx,
   input  wire vls_pkg::vls_lead_t   lead_rx,
   // Line drivers
   output vls_pkg::vls_pod_drv_t     drv,
   output logic                      load_switch_enable,
   output vls_pkg::vls_lead_t        lead_tx,
   output vls_pkg::vls_lead_t        lead_oe
);
   import vls_pkg::*;

   localparam int CW = $clog2(WORD_BITS + 1);

   // Differential driver truth: inhibit low, both off; else H sinks A
   function automatic vls_drv_t drive(input logic inh, input logic din);
      vls_drv_t d;
      d = '{a_on: inh & din, b_on: inh & ~din};
      return d;
   endfunction

   // pclk domain state
   logic [2:0]             pin_s1, pin_s2, pin_s3;
   vls_lead_t              lead_s1, lead_s2;
   logic                   term_mode, modem_mode;
   logic [4:0]             leads_reg;
   logic [WORD_BITS-1:0]   tx_word, rx_data;
   logic                   tx_req, ack_s1, ack_s2;
   logic                   rxt_s1, rxt_s2, rxt_s3;
   logic                   rx_valid, rx_reliable;
   // Link domain state
   logic                   lrst_s1, lrst_n;
   logic [3:0]             lk_s1, lk_s2;
   logic                   phase, tx_bit, tx_ack, rx_tgl;
   logic [WORD_BITS-1:0]   tx_sh, rx_sh, rx_word;
   logic [CW-1:0]          tx_cnt, rx_cnt;
   logic [1:0]             rxp_s1, rxp_s2;

   // APB decode
   wire setup     = psel & ~penable;
   wire access    = psel & penable & pready;
   wire wr        = access & pwrite;
   wire hit_ctrl  = paddr == VLS_ADDR_CTRL;
   wire hit_leads = paddr == VLS_ADDR_LEADS;
   wire hit_stat  = paddr == VLS_ADDR_STAT;
   wire hit_txd   = paddr == VLS_ADDR_TXD;
   wire hit_rxd   = paddr == VLS_ADDR_RXD;
   wire hit       = hit_ctrl | hit_leads | hit_stat | hit_txd | hit_rxd;
   wire ctrl_wr   = wr & hit_ctrl;

   // Mode select events: pin edges or software pulses
   wire [2:0] pin_rise  = pin_s2 & ~pin_s3;
   wire       mon_evt   = pin_rise[0] | (ctrl_wr & pwdata[VLS_CTRL_MON_BIT]);
   wire       term_evt  = pin_rise[1] | (ctrl_wr & pwdata[VLS_CTRL_TERM_BIT]);
   wire       modem_evt = pin_rise[2] | (ctrl_wr & pwdata[VLS_CTRL_MODEM_BIT]);
   // Monitor wins over a simulate pulse in the same cycle; a simulate pulse only sets its own mode
   wire next_term  = mon_evt ? 1'b0 : (term_evt  | term_mode);   // [RL16] [RL19]
   wire next_modem = mon_evt ? 1'b0 : (modem_evt | modem_mode);  // [RL16] [RL19]

   // Line permission for the simulated side
   wire tx_allow  = term_mode ? lead_s2.cs : (modem_mode & lead_s2.rs); // [RL6] [RL8]
   wire dce_ready = lead_s2.dsr & lead_s2.cs;                             // [RL9]
   wire tx_busy   = tx_req ^ ack_s2;
   wire rx_evt    = rxt_s2 ^ rxt_s3;
   wire rx_rd     = access & ~pwrite & hit_rxd;

   // Status word
   wire [31:0] stat;
   assign stat[VLS_STAT_TERM_BIT]  = term_mode;
   assign stat[VLS_STAT_MODEM_BIT] = modem_mode;
   assign stat[VLS_STAT_LOAD_BIT]  = load_switch_enable;
   assign stat[VLS_STAT_LEAD_LSB +: 5] = lead_s2;
   assign stat[VLS_STAT_RDY_BIT]   = dce_ready;
   assign stat[VLS_STAT_BUSY_BIT]  = tx_busy;
   assign stat[VLS_STAT_RXV_BIT]   = rx_valid;
   assign stat[VLS_STAT_REL_BIT]   = rx_reliable;
   assign stat[31:12]              = '0;

   // Read mux; control reads zero
   wire [31:0] rd_mux = hit_leads ? {27'h0, leads_reg} :
                        hit_stat  ? stat :
                        hit_rxd   ? 32'(rx_data) : 32'h0;

   // APB answer: zero wait, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~hit;
         prdata  <= setup ? rd_mux : 32'h0;
      end
   end

   // Pin and lead synchronisers, third stage only for edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1  <= 3'h0;
         pin_s2  <= 3'h0;
         pin_s3  <= 3'h0;
         lead_s1 <= '0;
         lead_s2 <= '0;
      end else begin
         pin_s1  <= {modem_sim_pulse, terminal_sim_pulse, monitor_pulse};
         pin_s2  <= pin_s1;
         pin_s3  <= pin_s2;
         lead_s1 <= lead_rx;
         lead_s2 <= lead_s1;
      end
   end

   // Mode flip-flops and load switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term_mode          <= 1'b0;
         modem_mode         <= 1'b0;
         load_switch_enable <= 1'b0;
      end else begin
         term_mode          <= next_term;
         modem_mode         <= next_modem;
         load_switch_enable <= next_term | next_modem; // [RL17] [RL13]
      end
   end

   // Control leads; each side's leads are driven only in its simulation mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         leads_reg <= VLS_LEADS_RST;
         lead_oe   <= '0;
         lead_tx   <= '0;
      end else begin
         if (wr & hit_leads) leads_reg <= pwdata[4:0];
         lead_oe <= '{rs: term_mode, dtr: term_mode, cs: modem_mode,
                      dsr: modem_mode, rlsd: modem_mode};      // [RL14] [RL7]
         lead_tx <= leads_reg & {term_mode, term_mode,
                                 modem_mode, modem_mode, modem_mode}; // [RL14]
      end
   end

   // Transmit request, held until the link side acknowledges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_req  <= 1'b0;
         tx_word <= '0;
         ack_s1  <= 1'b0;
         ack_s2  <= 1'b0;
      end else begin
         ack_s1 <= tx_ack;
         ack_s2 <= ack_s1;
         if (wr & hit_txd & ~tx_busy) begin
            tx_word <= pwdata[WORD_BITS-1:0];
            tx_req  <= ~tx_req;
         end
      end
   end

   // Receive word pickup; a new word beats a read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxt_s1      <= 1'b0;
         rxt_s2      <= 1'b0;
         rxt_s3      <= 1'b0;
         rx_data     <= '0;
         rx_valid    <= 1'b0;
         rx_reliable <= 1'b0;
      end else begin
         rxt_s1 <= rx_tgl;
         rxt_s2 <= rxt_s1;
         rxt_s3 <= rxt_s2;
         if (rx_evt) begin
            rx_data     <= rx_word;
            rx_reliable <= lead_s2.rlsd; // [RL10]
         end
         rx_valid <= rx_evt | (rx_valid & ~rx_rd);
      end
   end

   // Link reset: asynchronous assert, synchronous release
   always_ff @(posedge analyzer_clock_source or negedge presetn) begin
      if (!presetn) begin
         lrst_s1 <= 1'b0;
         lrst_n  <= 1'b0;
      end else begin
         lrst_s1 <= 1'b1;
         lrst_n  <= lrst_s1;
      end
   end

   // Levels into the link domain, receivers in too
   always_ff @(posedge analyzer_clock_source or negedge lrst_n) begin
      if (!lrst_n) begin
         lk_s1  <= 4'h0;
         lk_s2  <= 4'h0;
         rxp_s1 <= 2'h3;
         rxp_s2 <= 2'h3;
      end else begin
         lk_s1  <= {tx_req, tx_allow, modem_mode, term_mode};
         lk_s2  <= lk_s1;
         rxp_s1 <= {sd_rx, rd_rx};
         rxp_s2 <= rxp_s1;
      end
   end

   wire term_s   = lk_s2[0];
   wire modem_s  = lk_s2[1];
   wire allow_s  = lk_s2[2];
   wire req_s    = lk_s2[3];
   wire rise     = ~phase; // next edge raises the line clock
   wire tx_out   = allow_s ? tx_bit : 1'b1; // Idle mark while not permitted [RL6] [RL8]
   wire rx_in    = modem_s ? rxp_s2[1] : rxp_s2[0];

   // Bit shifter: new bit as the line clock rises, LSB first
   always_ff @(posedge analyzer_clock_source or negedge lrst_n) begin
      if (!lrst_n) begin
         phase  <= 1'b0;
         tx_bit <= 1'b1;
         tx_sh  <= '0;
         tx_cnt <= '0;
         tx_ack <= 1'b0;
      end else begin
         phase <= ~phase; // Clock at half the source rate [RL5]
         if (rise) begin  // Data moves with the positive-going clock [RL2] [RL4]
            if (tx_cnt != '0) begin
               tx_bit <= tx_sh[0];
               tx_sh  <= tx_sh >> 1;
               tx_cnt <= CW'(tx_cnt - 1'b1);
            end else if ((req_s != tx_ack) && allow_s) begin
               tx_bit <= tx_word[0];
               tx_sh  <= tx_word >> 1;
               tx_cnt <= CW'(WORD_BITS - 1);
               tx_ack <= ~tx_ack;
            end else begin
               tx_bit <= 1'b1; // Mark between words
            end
         end
      end
   end

   // Receive sampling on the falling line clock; free-running word framing
   always_ff @(posedge analyzer_clock_source or negedge lrst_n) begin
      if (!lrst_n) begin
         rx_sh   <= '0;
         rx_cnt  <= '0;
         rx_word <= '0;
         rx_tgl  <= 1'b0;
      end else if (!rise) begin // Sample at negative-going crossing [RL2]
         rx_sh <= {rx_in, rx_sh[WORD_BITS-1:1]};
         if (rx_cnt == CW'(WORD_BITS - 1)) begin
            rx_cnt  <= '0;
            rx_word <= {rx_in, rx_sh[WORD_BITS-1:1]};
            rx_tgl  <= ~rx_tgl;
         end else begin
            rx_cnt <= CW'(rx_cnt + 1'b1);
         end
      end
   end

   // Five drivers; clock input inverted so phase high gives A above B
   always_ff @(posedge analyzer_clock_source or negedge lrst_n) begin
      if (!lrst_n) begin
         drv <= '0;
      end else begin                          // [RL15] [RL12] [RL11]
         drv.sd   <= drive(term_s, tx_out);   // Mark sinks A: A below B [RL1]
         drv.scte <= drive(term_s, ~phase);   // Source runs from phase, not from a modem clock [RL3]
         drv.rd   <= drive(modem_s, tx_out);  // [RL1] [RL4]
         drv.scr  <= drive(modem_s, ~phase);  // [RL4]
         drv.sct  <= drive(modem_s, ~phase);  // [RL5]
      end
   end

   // Checks in the pclk domain
   a_mon_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
      mon_evt |=> !term_mode && !modem_mode) else $error("monitor left a mode set");
   a_term_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RL16]
      term_evt && !mon_evt |=> term_mode) else $error("terminal pulse did not set");
   a_load_sw: assert property (@(posedge pclk) disable iff (!presetn) // [RL17]
      load_switch_enable == (term_mode || modem_mode)) else $error("load switch wrong");
   a_lead_side: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
      !modem_mode ##1 1'b1 |-> !lead_oe.cs && !lead_oe.dsr && !lead_oe.rlsd)
      else $error("modem leads driven outside modem mode");
   a_rx_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
      rx_evt && rx_rd |=> rx_valid) else $error("receive word lost on clear");

   // Checks in the link domain
   a_inhibit_off: assert property (@(posedge analyzer_clock_source) disable iff (!lrst_n) // [RL11]
      !$past(term_s) |-> drv.sd == 2'b00 && drv.scte == 2'b00)
      else $error("inhibited driver still on");
   a_drv_excl: assert property (@(posedge analyzer_clock_source) disable iff (!lrst_n) // [RL11]
      !(drv.rd.a_on && drv.rd.b_on) && !(drv.sct.a_on && drv.sct.b_on))
      else $error("both driver outputs on");
   a_rd_gate: assert property (@(posedge analyzer_clock_source) disable iff (!lrst_n) // [RL6]
      $past(modem_s) && !$past(allow_s) |-> drv.rd.a_on)
      else $error("data sent without permission");
   a_data_phase: assert property (@(posedge analyzer_clock_source) disable iff (!lrst_n) // [RL2]
      $past(term_s, 2) && term_s && $changed(drv.sd) |-> drv.scte.b_on)
      else $error("data changed off the rising clock");
endmodule // vls_line_sim

/* File: design/vls_pkg.sv */
// Purpose: Shared constants and types of the V.35 line simulator pod logic
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   Lead value 1 means ON; driver a_on/b_on high means that output sinks
package vls_pkg;
   // Register byte offsets
   localparam logic [7:0] VLS_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] VLS_ADDR_LEADS = 8'h04;
   localparam logic [7:0] VLS_ADDR_STAT  = 8'h08;
   localparam logic [7:0] VLS_ADDR_TXD   = 8'h0c;
   localparam logic [7:0] VLS_ADDR_RXD   = 8'h10;
   // Control register bits (write-only pulses)
   localparam int VLS_CTRL_MON_BIT   = 0;
   localparam int VLS_CTRL_TERM_BIT  = 1;
   localparam int VLS_CTRL_MODEM_BIT = 2;
   // Status register fields
   localparam int VLS_STAT_TERM_BIT  = 0;
   localparam int VLS_STAT_MODEM_BIT = 1;
   localparam int VLS_STAT_LOAD_BIT  = 2;
   localparam int VLS_STAT_LEAD_LSB  = 3;
   localparam int VLS_STAT_RDY_BIT   = 8;
   localparam int VLS_STAT_BUSY_BIT  = 9;
   localparam int VLS_STAT_RXV_BIT   = 10;
   localparam int VLS_STAT_REL_BIT   = 11;
   // Leads reset value and serial word width
   localparam logic [4:0] VLS_LEADS_RST = 5'h00;
   localparam int         VLS_WORD_BITS = 8;
   // Nominal modem transmit clock, in kHz
   localparam int VLS_SCT_FREQ_KHZ = 1344;

   // Control leads, one bit each, 1 = ON
   typedef struct packed {
      logic rs;
      logic dtr;
      logic cs;
      logic dsr;
      logic rlsd;
   } vls_lead_t;

   // One differential driver: which output sinks current
   typedef struct packed {
      logic a_on;
      logic b_on;
   } vls_drv_t;

   // The five differential drivers of the pod
   typedef struct packed {
      vls_drv_t sd;
      vls_drv_t scte;
      vls_drv_t rd;
      vls_drv_t scr;
      vls_drv_t sct;
   } vls_pod_drv_t;
endpackage

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the V.35 pod line logic
// Assumes: Zero-wait APB slave; far device in vls_far_model
// Notes:   Transmit words keep bit0 low so the start shows after idle mark
`timescale 1ns/1ps
module testbench;
   import vls_pkg::*;
   logic         pclk = 0, aclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]   paddr = 0;
   logic [31:0]  pwdata = 0, prdata;
   logic         pready, pslverr, load_switch_enable, sd_rx, rd_rx;
   logic         monitor_pulse = 0, terminal_sim_pulse = 0, modem_sim_pulse = 0;
   logic         modem = 0, perm = 0, fill = 0;
   vls_lead_t    lead_rx, lead_tx, lead_oe;
   vls_pod_drv_t drv;
   int           bad_count = 0, samples_checked = 0, seed = 32'h8079, pair_bad;
   // Clocks: link clock free running, unrelated phase
   always #10 pclk = ~pclk;
   initial #7.3 forever #62.5 aclk = ~aclk;
   vls_line_sim i_vls_line_sim (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitor_pulse(monitor_pulse),
      .terminal_sim_pulse(terminal_sim_pulse), .modem_sim_pulse(modem_sim_pulse),
      .analyzer_clock_source(aclk), .sd_rx(sd_rx), .rd_rx(rd_rx), .lead_rx(lead_rx),
      .drv(drv), .load_switch_enable(load_switch_enable), .lead_tx(lead_tx),
      .lead_oe(lead_oe));
   vls_far_model i_vls_far_model (.aclk(aclk), .drv(drv), .lead_tx(lead_tx),
      .lead_oe(lead_oe), .modem(modem), .perm(perm), .fill(fill), .sd_rx(sd_rx),
      .rd_rx(rd_rx), .lead_rx(lead_rx), .pair_bad(pair_bad));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task end_sim;
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Registered answer is looked at mid-cycle, clear of the edge that moves it
      @(negedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(negedge pclk);
      end
      if (n == 50) bad_count++;
      r = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll a status bit with a bounded number of reads
   task wait_stat(input int b, input logic v);
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      apb(0, VLS_ADDR_STAT, 0, r, e);
      while (r[b] !== v && n < 400) begin
         n++;
         apb(0, VLS_ADDR_STAT, 0, r, e);
      end
      chk("stat_bit", r[b], v);
   endtask
   task wbits(input int n);
      for (int i = 0; i < 20000 && i_vls_far_model.bits.size() < n; i++) @(posedge pclk);
      chk("bit_count", i_vls_far_model.bits.size() >= n, 1);
   endtask
   // Mode pins held high four cycles, above the one-cycle minimum
   task pin(input int k);
      @(posedge pclk);
      {modem_sim_pulse, terminal_sim_pulse, monitor_pulse} <= 3'h1 << k;
      repeat (4) @(posedge pclk);
      {modem_sim_pulse, terminal_sim_pulse, monitor_pulse} <= 3'h0;
   endtask
   initial begin
      #500000;
      bad_count++;
      end_sim;
   end
   initial begin
      logic [31:0] r, w, word;
      logic        e;
      logic [4:0]  leads, oe;
      int          k;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, VLS_ADDR_LEADS, 0, r, e);
      chk("leads_rst", r, 32'(VLS_LEADS_RST));
      apb(0, VLS_ADDR_STAT, 0, r, e);
      chk("mode_rst", r[2:0], 0);
      apb(0, 8'h14, 0, r, e);
      chk("unmapped_err", e, 1);
      chk("unmapped_data", r, 0);
      for (int m = 0; m < 2; m++) begin
         modem <= m[0];
         fill <= !m[0];
         perm <= 1'b0;
         pin(0);
         pin(m + 1);
         wait_stat(m, 1);
         apb(0, VLS_ADDR_STAT, 0, r, e);
         chk("mode_bits", r[2:0], m ? 3'h6 : 3'h5);
         chk("load_switch", load_switch_enable, 1);
         leads = 5'($random(seed));
         apb(1, VLS_ADDR_LEADS, 32'(leads), r, e);
         apb(0, VLS_ADDR_LEADS, 0, r, e);
         chk("leads_rw", r, 32'(leads));
         repeat (40) @(posedge pclk);
         oe = m ? 5'h07 : 5'h18;
         chk("lead_oe", lead_oe, oe);
         chk("lead_tx", lead_tx, leads & oe);
         chk("other_side_off", m ? {drv.sd, drv.scte} : {drv.rd, drv.scr, drv.sct}, 0);
         w = 32'($random(seed)) & 32'hfe;
         i_vls_far_model.bits.delete();
         apb(1, VLS_ADDR_TXD, w, r, e);
         wbits(12);
         k = 0;
         foreach (i_vls_far_model.bits[i]) k += (i_vls_far_model.bits[i] !== 1'b1);
         chk("held_mark", k, 0);
         apb(0, VLS_ADDR_STAT, 0, r, e);
         chk("tx_busy", r[9], 1);
         perm <= 1'b1;
         i_vls_far_model.bits.delete();
         wbits(24);
         k = 0;
         while (k < 16 && i_vls_far_model.bits[k] !== 1'b0) k++;
         word = 0;
         for (int i = 0; i < VLS_WORD_BITS; i++) word[i] = i_vls_far_model.bits[k + i];
         chk("tx_word", word, w);
         wait_stat(9, 0);
         apb(0, VLS_ADDR_STAT, 0, r, e);
         chk("data_ready", r[8], m ? leads[2] & leads[1] : 1'b1);
         apb(0, VLS_ADDR_RXD, 0, r, e);
         wait_stat(10, 1);
         apb(0, VLS_ADDR_STAT, 0, r, e);
         chk("rx_reliable", r[11], m ? leads[0] : 1'b1);
         apb(0, VLS_ADDR_RXD, 0, r, e);
         chk("rx_word", r, fill ? 32'hff : 32'h0);
      end
      // Software select: monitor beats a simulate bit written with it
      apb(1, VLS_ADDR_CTRL, (32'h1 << VLS_CTRL_MON_BIT) | (32'h1 << VLS_CTRL_TERM_BIT), r, e);
      apb(0, VLS_ADDR_STAT, 0, r, e);
      chk("mon_wins", r[2:0], 3'h0);
      apb(1, VLS_ADDR_CTRL, 32'h1 << VLS_CTRL_TERM_BIT, r, e);
      apb(0, VLS_ADDR_STAT, 0, r, e);
      chk("ctrl_term", r[2:0], 3'h5);
      apb(1, VLS_ADDR_CTRL, 32'h1 << VLS_CTRL_MON_BIT, r, e);
      wait_stat(VLS_STAT_LOAD_BIT, 0);
      repeat (40) @(posedge pclk);
      chk("drv_off", drv, 0);
      chk("oe_off", lead_oe, 0);
      chk("pair_faults", pair_bad, 0);
      end_sim;
   end
endmodule // testbench

/* File: test/vls_far_model.sv */
// Purpose: Far-side V.35 device facing the pod lines
// Assumes: modem high means the pod plays the modem side
// Notes:   Pod data is sampled only at the falling line clock crossing
`timescale 1ns/1ps
module vls_far_model (
   // Pod drivers and leads
   input  wire logic                aclk,
   input  wire vls_pkg::vls_pod_drv_t drv,
   input  wire vls_pkg::vls_lead_t  lead_tx,
   input  wire vls_pkg::vls_lead_t  lead_oe,
   // Bench controls
   input  wire logic                modem,
   input  wire logic                perm,
   input  wire logic                fill,
   // Receiver outputs
   output logic                     sd_rx,
   output logic                     rd_rx,
   output vls_pkg::vls_lead_t       lead_rx,
   output int                       pair_bad
);
   import vls_pkg::*;
   logic      bits[$];
   vls_lead_t far;
   wire logic ck_neg = modem ? drv.scr.a_on : drv.scte.a_on;
   wire logic dat    = modem ? drv.rd.a_on : drv.sd.a_on;
   // Far modem answers cs/dsr/rlsd, far terminal raises rs/dtr
   assign far = modem ? vls_lead_t'({perm, 4'h8}) : vls_lead_t'({2'b00, perm, 2'b11});
   // Wire level: pod wins where it drives, else the far device
   assign lead_rx = vls_lead_t'((lead_oe & lead_tx) | (~lead_oe & far));
   // Constant fill keeps the receive word free of framing phase
   assign sd_rx = fill;
   assign rd_rx = fill;
   // Sample at negative-going crossing; mark is A sinking
   always @(posedge ck_neg) bits.push_back(dat);
   // A pair with both outputs on is a driver fault
   initial pair_bad = 0;
   always @(posedge aclk) begin
      for (int i = 0; i < 5; i++) if (drv[2*i] && drv[2*i+1]) pair_bad <= pair_bad + 1;
   end
endmodule // vls_far_model
